// >>> design/pll_reconfig_pkg.sv
/*
  Constants, state encoding and parameter-width decoding for the
  loop scan-chain reconfiguration controller.
  Assumes a single 125 MHz system clock and an APB register window.
*/

package pll_reconfig_pkg;

  localparam int CLK_NS        = 8;
  localparam int SCAN_HALF_NS  = 40;
  localparam int SCAN_HALF_CYC = (SCAN_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SCAN_DIV_LAST = 8'(SCAN_HALF_CYC - 1);
  localparam int ARESET_NS     = 64;
  localparam int ARESET_CYC    = (ARESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] AR_LAST = 4'(ARESET_CYC - 1);
  localparam logic [3:0] AR_END  = 4'(ARESET_CYC);

  localparam int CHAIN_LEN = 143;
  localparam logic [7:0] CHAIN_LAST = 8'(CHAIN_LEN - 1);
  localparam int SLOTS = 5;

  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  localparam int CMD_READ_BIT  = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_RECFG_BIT = 2;
  localparam int CMD_ARST_BIT  = 3;
  localparam int SEL_PARAM_LSB = 4;

  localparam logic [3:0] TYPE_PRE  = 4'h0;
  localparam logic [3:0] TYPE_FB   = 4'h1;
  localparam logic [3:0] TYPE_CPLF = 4'h2;
  localparam logic [3:0] TYPE_VCO  = 4'h3;
  localparam logic [3:0] TYPE_C4   = 4'h8;

  localparam logic [2:0] PAR_HIGH   = 3'h0;
  localparam logic [2:0] PAR_LOW    = 3'h1;
  localparam logic [2:0] PAR_LF_CAP = 3'h2;
  localparam logic [2:0] PAR_BYPASS = 3'h4;
  localparam logic [2:0] PAR_MODE   = 3'h5;
  localparam logic [2:0] PAR_NOM    = 3'h7;

  localparam logic [8:0] CACHE_RESET = 9'h000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_SHIFT = 3'b011,
    ST_WAIT  = 3'b100,
    ST_RESET = 3'b101
  } state_type;

  // Field width in bits, zero where the pair does not exist
  function automatic logic [3:0] param_width(input logic [3:0] ty, input logic [2:0] pa);
    param_width = 4'h0;
    if (ty == TYPE_CPLF) begin
      case (pa)
        PAR_HIGH:   param_width = 4'h3;
        PAR_LOW:    param_width = 4'h5;
        PAR_LF_CAP: param_width = 4'h2;
        PAR_BYPASS: param_width = 4'h1;
        PAR_MODE:   param_width = 4'h5;
        default:    param_width = 4'h0;
      endcase
    end else if (ty == TYPE_VCO) begin
      param_width = (pa == PAR_HIGH) ? 4'h1 : 4'h0;
    end else if (ty <= TYPE_C4) begin
      case (pa)
        PAR_HIGH, PAR_LOW:   param_width = 4'h8;
        PAR_BYPASS, PAR_MODE: param_width = 4'h1;
        PAR_NOM:  param_width = (ty <= TYPE_FB) ? 4'h9 : 4'h0;
        default:  param_width = 4'h0;
      endcase
    end
  endfunction

  // Param codes in scan order within one counter
  function automatic logic [2:0] slot_param(input int k);
    case (k)
      0:       slot_param = PAR_HIGH;
      1:       slot_param = PAR_LOW;
      2:       slot_param = PAR_LF_CAP;
      3:       slot_param = PAR_BYPASS;
      default: slot_param = PAR_MODE;
    endcase
  endfunction

endpackage

// >>> design/bit_sync.sv
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes the input is a slow level; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none

module bit_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Level in and out
  input  wire logic din,
  output logic      dout_r
);

  logic meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      meta_r <= din;
      dout_r <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> design/scan_clk_gen.sv
/*
  Scan clock divider: a low-idle clock with edge pulses while run is high.
  Assumes run drops only while the scan clock is low.
*/
`timescale 1ns/1ps
`default_nettype none

module scan_clk_gen
  import pll_reconfig_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic run,
  // Scan clock and edge marks
  output logic      scan_clk_r,
  output logic      rise_p_r,
  output logic      fall_p_r
);

  logic [7:0] div_r;
  logic       term;

  assign term = run && (div_r == SCAN_DIV_LAST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r      <= 8'h00;
      scan_clk_r <= 1'b0;
    end else if (!run) begin
      div_r      <= 8'h00;
      scan_clk_r <= 1'b0;
    end else if (term) begin
      div_r      <= 8'h00;
      scan_clk_r <= !scan_clk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Pulses line up with the cycle the scan clock has just changed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_p_r <= 1'b0;
      fall_p_r <= 1'b0;
    end else begin
      rise_p_r <= term && !scan_clk_r;
      fall_p_r <= term && scan_clk_r;
    end
  end

endmodule

`default_nettype wire

// >>> design/pll_scan_reconfig_controller.sv
/*
  Loop scan-chain reconfiguration controller: APB register window,
  parameter cache, nominal-count expansion and serial chain shifter.
  Assumes an APB master on clk and a loop whose scan-done is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module pll_scan_reconfig_controller
  import pll_reconfig_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Loop scan port
  input  wire logic        pll_scandone,
  output logic             pll_scanclk,
  output logic             pll_scanclkena,
  output logic             pll_scandata,
  output logic             pll_configupdate,
  output logic             pll_areset
);

  state_type      state_r;
  logic [8:0]     cache_r [0:8][0:7];
  logic [3:0]     sel_type_r;
  logic [2:0]     sel_param_r;
  logic [8:0]     wdata_r;
  logic [8:0]     data_out_r;
  logic           arst_req_r;
  logic [3:0]     op_ty_r;
  logic [2:0]     op_pa_r;
  logic [8:0]     op_data_r;
  logic [7:0]     bit_idx_r;
  logic [3:0]     ar_cnt_r;
  logic           done_s;
  logic           done_d_r;
  logic           rise_p;
  logic           fall_p;
  logic           busy;
  logic           setup;
  logic           wr_acc;
  logic           cmd_wr;
  logic           cmd_go;
  logic           hit;
  logic [31:0]    rd_mux;
  logic [CHAIN_LEN-1:0] chain;
  int             pos;
  logic [3:0]     w;
  logic [3:0]     op_w;
  logic [8:0]     op_mask;
  logic [8:0]     nom_hi;
  logic [8:0]     nom_lo;
  logic           last_fall;

  bit_sync u_done_sync (
    .clk    (clk),
    .rstn   (rstn),
    .din    (pll_scandone),
    .dout_r (done_s)
  );

  scan_clk_gen u_scan_clk (
    .clk        (clk),
    .rstn       (rstn),
    .run        (state_r == ST_SHIFT),
    .scan_clk_r (pll_scanclk),
    .rise_p_r   (rise_p),
    .fall_p_r   (fall_p)
  );

  assign busy      = (state_r != ST_IDLE);
  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pready && pwrite;
  assign cmd_wr    = wr_acc && (paddr == OFF_CMD);
  assign last_fall = (state_r == ST_SHIFT) && fall_p && (bit_idx_r == CHAIN_LAST);

  // Accepted only when idle; illegal type drops read and write
  assign cmd_go = cmd_wr && !busy && (pwdata[CMD_RECFG_BIT] ||
                  ((pwdata[CMD_READ_BIT] || pwdata[CMD_WRITE_BIT]) && sel_type_r <= TYPE_C4));

  assign op_w    = param_width(op_ty_r, op_pa_r);
  assign op_mask = 9'((10'h001 << op_w) - 10'h001);
  assign nom_hi  = {1'b0, op_data_r[8:1]} + {8'h00, op_data_r[0]};
  assign nom_lo  = op_data_r - nom_hi;

  // Register read mux and address decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    case (paddr)
      OFF_CMD:    rd_mux[CMD_ARST_BIT] = arst_req_r;
      OFF_SEL:    rd_mux[6:0] = {sel_param_r, sel_type_r};
      OFF_WDATA:  rd_mux[8:0] = wdata_r;
      OFF_RDATA:  rd_mux[8:0] = data_out_r;
      OFF_STATUS: rd_mux[2:0] = {pll_areset, done_s, busy};
      default:    hit = 1'b0;
    endcase
  end

  // One wait-free access phase per setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_type_r  <= 4'h0;
      sel_param_r <= 3'h0;
      wdata_r     <= 9'h000;
      arst_req_r  <= 1'b0;
    end else begin
      if (wr_acc && paddr == OFF_SEL) begin
        sel_type_r  <= pwdata[3:0];
        sel_param_r <= pwdata[SEL_PARAM_LSB+2:SEL_PARAM_LSB];
      end
      if (wr_acc && paddr == OFF_WDATA) begin
        wdata_r <= pwdata[8:0];
      end
      if (cmd_wr) begin
        arst_req_r <= pwdata[CMD_ARST_BIT];
      end
    end
  end

  // Whole chain flattened from the cache, counter by counter, MSB first
  always_comb begin
    chain = '0;
    pos   = 0;
    w     = 4'h0;
    for (int t = 0; t <= int'(TYPE_C4); t++) begin
      for (int k = 0; k < SLOTS; k++) begin
        w = param_width(4'(t), slot_param(k));
        for (int b = 0; b < 9; b++) begin
          if (b < int'(w)) begin
            chain[pos] = cache_r[t][slot_param(k)][int'(w) - 1 - b];
            pos = pos + 1;
          end
        end
      end
    end
  end

  // Cache: changed only by parameter writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int t = 0; t < 9; t++) begin
        for (int p = 0; p < 8; p++) begin
          cache_r[t][p] <= CACHE_RESET;
        end
      end
    end else if (state_r == ST_WRITE) begin
      if (op_pa_r == PAR_NOM) begin
        if (op_w != 4'h0) begin
          cache_r[op_ty_r][PAR_NOM]    <= op_data_r;
          cache_r[op_ty_r][PAR_HIGH]   <= {1'b0, nom_hi[7:0]};
          cache_r[op_ty_r][PAR_LOW]    <= {1'b0, nom_lo[7:0]};
          cache_r[op_ty_r][PAR_MODE]   <= {8'h00, op_data_r[0]};
          cache_r[op_ty_r][PAR_BYPASS] <= {8'h00, op_data_r == 9'h001};
        end
      end else if (op_w != 4'h0) begin
        cache_r[op_ty_r][op_pa_r] <= op_data_r & op_mask;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r          <= ST_IDLE;
      op_ty_r          <= 4'h0;
      op_pa_r          <= 3'h0;
      op_data_r        <= 9'h000;
      data_out_r       <= 9'h000;
      bit_idx_r        <= 8'h00;
      ar_cnt_r         <= 4'h0;
      pll_scanclkena   <= 1'b0;
      pll_scandata     <= 1'b0;
      pll_configupdate <= 1'b0;
    end else begin
      pll_configupdate <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_go) begin
            op_ty_r   <= sel_type_r;
            op_pa_r   <= sel_param_r;
            op_data_r <= wdata_r;
            bit_idx_r <= 8'h00;
            if (pwdata[CMD_RECFG_BIT]) begin
              state_r <= ST_SHIFT;
            end else if (pwdata[CMD_WRITE_BIT]) begin
              state_r <= ST_WRITE;
            end else begin
              state_r <= ST_READ;
            end
          end
        end
        ST_READ: begin
          data_out_r <= cache_r[op_ty_r][op_pa_r] & op_mask;
          state_r    <= ST_IDLE;
        end
        ST_WRITE: begin
          state_r <= ST_IDLE;
        end
        ST_SHIFT: begin
          if (!pll_scanclkena) begin
            pll_scanclkena <= 1'b1;
            pll_scandata   <= chain[0];
          end else if (fall_p) begin
            if (bit_idx_r == CHAIN_LAST) begin
              pll_scanclkena   <= 1'b0;
              pll_scandata     <= 1'b0;
              pll_configupdate <= 1'b1;
              state_r          <= ST_WAIT;
            end else begin
              bit_idx_r    <= bit_idx_r + 8'h01;
              pll_scandata <= chain[bit_idx_r + 8'h01];
            end
          end
        end
        ST_WAIT: begin
          if (done_s && !done_d_r) begin
            ar_cnt_r <= 4'h0;
            state_r  <= ST_RESET;
          end
        end
        ST_RESET: begin
          ar_cnt_r <= ar_cnt_r + 4'h1;
          if (ar_cnt_r == AR_END) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_d_r   <= 1'b0;
      pll_areset <= 1'b0;
    end else begin
      done_d_r   <= done_s;
      pll_areset <= arst_req_r ||
                    (state_r == ST_WAIT && done_s && !done_d_r) ||
                    (state_r == ST_RESET && ar_cnt_r < AR_LAST);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence last_bit_s;
    last_fall;
  endsequence

  sequence update_pulse_s;
    pll_configupdate && !pll_scanclkena ##1 !pll_configupdate;
  endsequence

  busy_late_a: assert property ($rose(busy) |-> $past(cmd_go))
    else $error("busy rose without a request in the prior cycle");
  busy_hold_a: assert property (
    cmd_go |=> busy && op_ty_r == $past(sel_type_r) && op_pa_r == $past(sel_param_r))
    else $error("busy or latched selection wrong after an accepted request");
  no_cmd_busy_a: assert property (
    busy && cmd_wr |=> state_r != ST_READ && state_r != ST_WRITE)
    else $error("request taken while busy");
  illegal_type_a: assert property (
    cmd_wr && !busy && !pwdata[CMD_RECFG_BIT] && sel_type_r > TYPE_C4 |=> !busy)
    else $error("illegal counter type raised busy");
  update_after_a: assert property (last_bit_s |=> update_pulse_s)
    else $error("update did not pulse once after the last bit");
  reset_done_a: assert property (
    state_r == ST_WAIT && done_s && !done_d_r |=> pll_areset)
    else $error("loop reset missed scan-done");
  reset_req_a: assert property (arst_req_r |=> pll_areset)
    else $error("loop reset did not follow the request");
  busy_after_rst_a: assert property (
    $fell(busy) && $past(state_r) == ST_RESET
      |-> ($past(arst_req_r) || !$past(pll_areset)) && $past(pll_areset, 2))
    else $error("busy fell before loop reset pulsed and ended");
  quiet_data_a: assert property (
    state_r != ST_SHIFT |-> !pll_scandata && !pll_scanclkena)
    else $error("scan data active outside reconfiguration");
  ena_low_clk_a: assert property ($rose(pll_scanclkena) |-> !pll_scanclk)
    else $error("enable raised while scan clock high");
  data_hold_a: assert property (
    rise_p && pll_scanclkena |-> $stable(pll_scandata))
    else $error("scan data changed at a scan clock rise");
  read_data_a: assert property (
    state_r == ST_READ |=> data_out_r == (cache_r[op_ty_r][op_pa_r] & op_mask))
    else $error("read data does not match cache");
  nominal_a: assert property (
    state_r == ST_WRITE && op_pa_r == PAR_NOM && op_w != 4'h0 && op_data_r < 9'h100
      |=> cache_r[op_ty_r][PAR_HIGH] + cache_r[op_ty_r][PAR_LOW] == op_data_r)
    else $error("nominal count split wrongly");

endmodule

`default_nettype wire

// >>> bench/loop_scan_model.sv
/*
  Behavioural loop on the far side of the scan port: captures shifted
  bits, counts update strobes and resets, and answers with scan-done.
  Assumes the controller drives a low-idle scan clock and its enable.
*/
`timescale 1ns/1ps
`default_nettype none

module loop_scan_model (
  // Scan port from the controller
  input  wire logic        scanclk,
  input  wire logic        scanclkena,
  input  wire logic        scandata,
  input  wire logic        configupdate,
  input  wire logic        areset,
  // Answer delay in ns
  input  wire logic [15:0] done_dly,
  // Back to the controller
  output logic             scandone
);
  logic bits[$];
  int   cfg_count;
  int   rst_count;

  initial begin
    scandone = 1'b0;
    cfg_count = 0;
    rst_count = 0;
  end

  always @(posedge scanclk) begin
    if (scanclkena) begin
      bits.push_back(scandata);
    end
  end

  always @(posedge scanclkena) begin
    scandone <= 1'b0;
  end

  always @(posedge configupdate) begin
    cfg_count++;
    #(done_dly) scandone <= 1'b1;
  end

  always @(posedge areset) begin
    rst_count++;
  end
endmodule

`default_nettype wire

// >>> bench/pll_scan_reconfig_controller_tb.sv
/*
  Self-checking bench: APB master, cache model and chain comparison.
  Assumes the register map and timing of the controller hand-over.
*/
`timescale 1ns/1ps
`default_nettype none

module pll_scan_reconfig_controller_tb
  import pll_reconfig_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, pll_scandone;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic        pready, pslverr, e, pll_scanclk, pll_scanclkena;
  logic        pll_scandata, pll_configupdate, pll_areset;
  logic [15:0] done_dly;
  int          bad_count, num_checks;
  int          cache[9][8];
  int          pl[5] = '{0, 1, 2, 4, 5};

  pll_scan_reconfig_controller dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_scandone(pll_scandone), .pll_scanclk(pll_scanclk),
    .pll_scanclkena(pll_scanclkena), .pll_scandata(pll_scandata),
    .pll_configupdate(pll_configupdate), .pll_areset(pll_areset));

  // Loop reset wired straight through
  loop_scan_model u_loop (.scanclk(pll_scanclk), .scanclkena(pll_scanclkena),
    .scandata(pll_scandata), .configupdate(pll_configupdate), .areset(pll_areset),
    .done_dly(done_dly), .scandone(pll_scandone));

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int wid(int t, int p);
    if (t == 2) return (p == 0) ? 3 : (p == 1) ? 5 : (p == 2) ? 2 :
                       (p == 4) ? 1 : (p == 5) ? 5 : 0;
    if (t == 3) return (p == 0) ? 1 : 0;
    if (t > 8) return 0;
    return (p < 2) ? 8 : (p == 4 || p == 5) ? 1 : 0;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic setup(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
  endtask

  task automatic acc();
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask

  task automatic rel();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    setup(w, a, d);
    acc();
    rel();
  endtask

  // Command write followed at once by a status read
  task automatic cmd_status(input logic [31:0] cmd);
    setup(1'b1, OFF_CMD, cmd);
    acc();
    setup(1'b0, OFF_STATUS, 32'h0);
    acc();
    rel();
  endtask

  task automatic idle();
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
    end while (q[0] !== 1'b0);
  endtask

  task automatic op(input int t, input int p, input logic [31:0] cmd, input logic [31:0] d);
    apb(1'b1, OFF_SEL, 32'((p << SEL_PARAM_LSB) | t));
    apb(1'b1, OFF_WDATA, d);
    cmd_status(cmd);
    chk(q[0], t < 9, "busy after command");
    idle();
  endtask

  task automatic wr(input int t, input int p, input int d);
    int h;
    op(t, p, 32'h2, d);
    if (t < 2 && p == 7) begin
      h = (d + 1) / 2;
      cache[t][0] = h & 255;
      cache[t][1] = d - h;
      cache[t][5] = d % 2;
      cache[t][4] = (d == 1);
      cache[t][7] = d;
    end else if (wid(t, p) > 0) cache[t][p] = d & ((1 << wid(t, p)) - 1);
  endtask

  task automatic rd(input int t, input int p);
    op(t, p, 32'h1, 32'h0);
    apb(1'b0, OFF_RDATA, 32'h0);
    if (t < 9) chk(q, cache[t][p], "read data");
  endtask

  task automatic recfg(input logic [15:0] dly, input bit intrude);
    int r0, c0, i;
    done_dly <= dly;
    u_loop.bits.delete();
    r0 = u_loop.rst_count;
    c0 = u_loop.cfg_count;
    cmd_status(32'h4);
    chk(q[0], 1'b1, "busy after reconfig");
    if (intrude) op(0, 0, 32'h2, 32'h55);
    idle();
    chk(q[1], 1'b1, "scan done status");
    chk(u_loop.rst_count - r0, 1, "loop resets");
    chk(u_loop.cfg_count - c0, 1, "update pulses");
    chk(pll_areset, 1'b0, "loop reset after busy");
    chk(u_loop.bits.size(), CHAIN_LEN, "chain length");
    i = 0;
    for (int t = 0; t < 9; t++)
      for (int k = 0; k < 5; k++)
        for (int b = wid(t, pl[k]) - 1; b >= 0; b--) begin
          if (i < u_loop.bits.size())
            chk(u_loop.bits[i], (cache[t][pl[k]] >> b) & 1, "chain bit");
          i++;
        end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rstn === 1'b1 && pll_scanclkena !== 1'b1) chk(pll_scandata, 1'b0, "scan data quiet");
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    done_dly = 16'h00c8;
    seed = 32'hba0c;
    bad_count = 0;
    num_checks = 0;
    foreach (cache[t, p]) cache[t][p] = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    recfg(16'h0028, 1'b0);
    $display("test reset chain done");
    for (int t = 0; t < 16; t++)
      for (int k = 0; k < 5; k++) begin
        wr(t, pl[k], rnd() & 511);
        rd(t, pl[k]);
      end
    $display("test cache access done");
    foreach (pl[n]) begin
      wr(n % 2, 7, (n == 0) ? 1 : (n % 2 == 1) ? (rnd() & 126) + 2 : (rnd() & 126) + 3);
      for (int k = 0; k < 5; k++) rd(n % 2, pl[k]);
      rd(n % 2, 7);
    end
    $display("test nominal count done");
    recfg(16'h0028, 1'b1);
    recfg(16'h0bb8, 1'b0);
    $display("test reconfiguration done");
    cmd_status(32'h8);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(q[2], 1'b1, "loop reset status");
    apb(1'b0, OFF_CMD, 32'h0);
    chk(q[3], 1'b1, "loop reset request readback");
    chk(pll_areset, 1'b1, "loop reset request");
    cmd_status(32'h0);
    chk(pll_areset, 1'b0, "loop reset release");
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1, "unmapped read error");
    chk(q, 32'h0, "unmapped read data");
    apb(1'b1, 8'h20, 32'h1);
    chk(e, 1'b1, "unmapped write error");
    $display("test reset request and unmapped done");
    stop_test();
  end
endmodule

`default_nettype wire
